// *** common/cmcrc_map.svh ***
`ifndef CMCRC_MAP_SVH
`define CMCRC_MAP_SVH

// ********************************************************************
// Checker constants
// ********************************************************************

// Generator polynomial of the 32-bit CRC, normal form, shifted MSB first.
`define CMCRC_POLY        32'h04C1_1DB7
// Start value of every frame check and every user pass.
`define CMCRC_CRC_INIT    32'hFFFF_FFFF
// Signature of a clean pass.
`define CMCRC_SIG_CLEAN   32'h0000_0000
// Reset value of the reference store and of the compared reference.
`define CMCRC_REF_RESET   32'h0000_0000
// Largest divider exponent: the rate is the source over two to the n.
`define CMCRC_DIV_MAX     4'h8
// Divider exponent used after reset.
`define CMCRC_DIV_RESET   4'h0
// Nominal oscillator rate in kHz, and the slowest rate it is divided to.
`define CMCRC_OSC_KHZ     80000
`define CMCRC_MIN_KHZ     312.5

`endif

// *** common/cmcrc_pkg.sv ***
// ********************************************************************
// Shared types of the configuration memory checker
// ********************************************************************

package cmcrc_pkg;

    // Sequencing states, one-hot.
    typedef enum logic [3:0] {
        CMCRC_ST_LOAD = 4'b0001,
        CMCRC_ST_FAIL = 4'b0010,
        CMCRC_ST_IDLE = 4'b0100,
        CMCRC_ST_USER = 4'b1000
    } cmcrc_state_t;

    // Meaning of a word arriving on the load stream.
    typedef enum logic [1:0] {
        CMCRC_KIND_DATA  = 2'b00,
        CMCRC_KIND_FRAME = 2'b01,
        CMCRC_KIND_REF   = 2'b10
    } cmcrc_kind_t;

endpackage : cmcrc_pkg

// *** design/cmcrc_engine.sv ***
`timescale 1ns/100ps

// ********************************************************************
// One 32-bit word folded into a running CRC
// ********************************************************************

`include "cmcrc_map.svh"

module cmcrc_engine
(
    input  wire logic [31:0] crc_in,
    input  wire logic [31:0] data_in,
    output logic      [31:0] crc_out
);
    import cmcrc_pkg::*;

    localparam logic [31:0] POLY = `CMCRC_POLY;

    logic [31:0] stage [0:32];

    assign stage[0] = crc_in;

    // One shift per data bit, most significant bit first; the whole word
    // settles in one cycle, which costs depth but keeps the scan simple.
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_bit
            assign stage[i+1] = (stage[i][31] ^ data_in[31-i]) ?
                                ({stage[i][30:0], 1'b0} ^ POLY) :
                                {stage[i][30:0], 1'b0};
        end
    endgenerate

    assign crc_out = stage[32];

endmodule : cmcrc_engine

// *** design/cmcrc_checker.sv ***

`timescale 1ns/100ps

`include "cmcrc_map.svh"

module cmcrc_checker
#(
    parameter int CELL_WORDS = 64
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  config_restart_n,
    input  wire logic                  check_enable,
    input  wire logic [3:0]            div_exp,
    input  wire logic                  cfg_valid,
    input  wire cmcrc_pkg::cmcrc_kind_t cfg_kind,
    input  wire logic [31:0]           cfg_word,
    input  wire logic                  load_reference_instr,
    input  wire logic                  ref_shift,
    input  wire logic                  ref_tdi,
    output logic                       ref_tdo,
    output logic                       config_done,
    output logic                       config_frame_error,
    output logic                       user_mode,
    output logic [31:0]                crc_check_signature,
    output logic                       crc_error
);
    import cmcrc_pkg::*;

    localparam int AW = (CELL_WORDS > 1) ? $clog2(CELL_WORDS) : 1;
    localparam logic [AW:0] CELL_WORDS_W = (AW+1)'(CELL_WORDS);

    // ****************************************************************
    // Storage and state
    // ****************************************************************

    // The configuration cell array; memory blocks and I/O state live elsewhere.
    logic [31:0]  config_cell_array [0:CELL_WORDS-1];

    cmcrc_state_t state_q;
    logic         hold_rst;
    logic [AW:0]  wr_ptr_q;
    logic [AW:0]  used_q;
    logic [AW-1:0] rd_ptr_q;
    logic [31:0]  frame_crc_q;
    logic [31:0]  frame_crc_d;
    logic [31:0]  pass_crc_q;
    logic [31:0]  pass_crc_d;
    logic [31:0]  crc_reference_store_q;
    logic [31:0]  cmp_ref_q;
    logic [31:0]  signature_q;
    logic         fault_q;
    logic [7:0]   div_cnt_q;
    logic [7:0]   div_mask;
    logic [3:0]   div_n;
    logic         tick;
    logic         pass_last;
    logic         pass_end;
    logic         take_data;
    logic         take_frame;
    logic         take_ref;
    logic         frame_bad;
    logic         scan_step;

    // The restart pin resets the checker the same way the core reset does.
    assign hold_rst = rst | ~config_restart_n;

    // ****************************************************************
    // Load stream decode
    // ****************************************************************

    assign take_data  = cfg_valid && (state_q == CMCRC_ST_LOAD) && (cfg_kind == CMCRC_KIND_DATA);
    assign take_frame = cfg_valid && (state_q == CMCRC_ST_LOAD) && (cfg_kind == CMCRC_KIND_FRAME);
    assign take_ref   = cfg_valid && (state_q == CMCRC_ST_LOAD) && (cfg_kind == CMCRC_KIND_REF);
    assign frame_bad  = take_frame && (cfg_word != frame_crc_q);

    cmcrc_engine u_frame_crc
    (
        .crc_in  (frame_crc_q),
        .data_in (cfg_word),
        .crc_out (frame_crc_d)
    );

    // Frame words go into the array; words past its end are dropped.
    always_ff @(posedge core_clk)
    begin
        if (take_data && (wr_ptr_q < CELL_WORDS_W))
        begin
            config_cell_array[wr_ptr_q[AW-1:0]] <= cfg_word;
        end
    end

    // Write pointer counts the configured words.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            wr_ptr_q <= '0;
        else if (take_data && (wr_ptr_q < CELL_WORDS_W))
            wr_ptr_q <= wr_ptr_q + 1'b1;
    end

    // Running frame CRC restarts after every frame check word.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst || take_frame)
            frame_crc_q <= `CMCRC_CRC_INIT;
        else if (take_data)
            frame_crc_q <= frame_crc_d;
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // A frame mismatch stops loading for good; only a core reset or a restart leaves it.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            state_q <= CMCRC_ST_LOAD;
        else
        begin
            case (state_q)
                CMCRC_ST_LOAD:
                begin
                    if (frame_bad)
                        state_q <= CMCRC_ST_FAIL;
                    else if (take_ref)
                        state_q <= check_enable ? CMCRC_ST_USER : CMCRC_ST_IDLE;
                end
                CMCRC_ST_FAIL: state_q <= CMCRC_ST_FAIL;
                CMCRC_ST_IDLE: state_q <= CMCRC_ST_IDLE;
                CMCRC_ST_USER: state_q <= CMCRC_ST_USER;
                default:       state_q <= CMCRC_ST_LOAD;
            endcase
        end
    end

    // Number of configured words frozen when loading ends.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            used_q <= '0;
        else if (take_ref)
            used_q <= wr_ptr_q;
    end

    // ****************************************************************
    // Reference store and its scan chain
    // ****************************************************************

    // Shifting towards bit 0 lets the host read the old value out while the
    // new one goes in, so a read-out costs no extra instruction.
    assign scan_step = load_reference_instr && ref_shift;

    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            crc_reference_store_q <= `CMCRC_REF_RESET;
        else if (take_ref)
            crc_reference_store_q <= cfg_word;
        else if (scan_step)
            crc_reference_store_q <= {ref_tdi, crc_reference_store_q[31:1]};
    end

    assign ref_tdo = crc_reference_store_q[0];

    // ****************************************************************
    // Check clock divider
    // ****************************************************************

    // Exponents above the largest one are clamped rather than wrapped.
    assign div_n    = (div_exp > `CMCRC_DIV_MAX) ? `CMCRC_DIV_MAX : div_exp;
    assign div_mask = 8'((9'h001 << div_n) - 9'h001);
    assign tick     = ((div_cnt_q & div_mask) == div_mask);

    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            div_cnt_q <= '0;
        else
            div_cnt_q <= div_cnt_q + 8'h01;
    end

    // ****************************************************************
    // User mode pass over the cells
    // ****************************************************************

    assign pass_last = ({1'b0, rd_ptr_q} + 1'b1) >= used_q;
    assign pass_end  = (state_q == CMCRC_ST_USER) && tick && pass_last;

    cmcrc_engine u_pass_crc
    (
        .crc_in  (pass_crc_q),
        .data_in (config_cell_array[rd_ptr_q]),
        .crc_out (pass_crc_d)
    );

    // The scan never waits on the reference instruction.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst || (state_q != CMCRC_ST_USER))
            rd_ptr_q <= '0;
        else if (tick)
            rd_ptr_q <= pass_last ? '0 : rd_ptr_q + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (hold_rst || (state_q != CMCRC_ST_USER) || pass_end)
            pass_crc_q <= `CMCRC_CRC_INIT;
        else if (tick)
            pass_crc_q <= pass_crc_d;
    end

    // The reference is sampled at each pass start, so a scan in progress
    // only takes effect from the following pass. The load-end word is taken
    // straight from the stream, because the store only holds it one edge later
    // and the first pass would otherwise compare against a stale value.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
            cmp_ref_q <= `CMCRC_REF_RESET;
        else if (take_ref)
            cmp_ref_q <= cfg_word;
        else if ((state_q != CMCRC_ST_USER) || pass_end)
            cmp_ref_q <= crc_reference_store_q;
    end

    // Signature and fault change only at a pass end; nothing is latched.
    always_ff @(posedge core_clk)
    begin
        if (hold_rst)
        begin
            signature_q <= `CMCRC_SIG_CLEAN;
            fault_q     <= 1'b0;
        end
        else if (pass_end)
        begin
            signature_q <= pass_crc_d ^ cmp_ref_q;
            fault_q     <= ((pass_crc_d ^ cmp_ref_q) != `CMCRC_SIG_CLEAN);
        end
    end

    assign crc_check_signature = signature_q;
    assign crc_error           = fault_q;
    assign config_done         = state_q[2] | state_q[3];
    assign config_frame_error  = state_q[1];
    assign user_mode           = state_q[3];

    // ****************************************************************
    // Checks
    // ****************************************************************

    a_fault_follows_sig: assert property (@(posedge core_clk) disable iff (hold_rst)
        crc_error == (crc_check_signature != `CMCRC_SIG_CLEAN))
        else $error("Fault output disagrees with signature.");

    a_restart_clears: assert property (@(posedge core_clk)
        !config_restart_n |=> (state_q == CMCRC_ST_LOAD) && !crc_error)
        else $error("Restart did not stop the checker.");

    a_frame_halt: assert property (@(posedge core_clk) disable iff (hold_rst)
        frame_bad |=> config_frame_error [*3])
        else $error("Frame mismatch did not halt loading.");

    a_ref_stored: assert property (@(posedge core_clk) disable iff (hold_rst)
        take_ref |=> crc_reference_store_q == $past(cfg_word))
        else $error("Reference not stored at load end.");

    a_auto_start: assert property (@(posedge core_clk) disable iff (hold_rst)
        take_ref && check_enable && !frame_bad |=> user_mode)
        else $error("Checking did not start on user mode entry.");

    a_scan_chain: assert property (@(posedge core_clk) disable iff (hold_rst)
        scan_step && !take_ref |=> crc_reference_store_q ==
            {$past(ref_tdi), $past(crc_reference_store_q[31:1])})
        else $error("Reference scan chain shifted wrongly.");

    a_scan_no_halt: assert property (@(posedge core_clk) disable iff (hold_rst)
        user_mode && scan_step && tick && !pass_last |=> rd_ptr_q == $past(rd_ptr_q) + 1'b1)
        else $error("Scan instruction stalled the pass.");

    a_sig_at_end: assert property (@(posedge core_clk) disable iff (hold_rst)
        pass_end |=> crc_check_signature == ($past(pass_crc_d) ^ $past(cmp_ref_q)))
        else $error("Signature not updated at pass end.");

    a_fault_holds: assert property (@(posedge core_clk) disable iff (hold_rst)
        !pass_end |=> $stable(crc_error) && $stable(crc_check_signature))
        else $error("Fault changed between pass ends.");

    a_first_pass_ref: assert property (@(posedge core_clk) disable iff (hold_rst)
        take_ref |=> cmp_ref_q == $past(cfg_word))
        else $error("First pass does not compare against the loaded reference.");

    a_ref_per_pass: assert property (@(posedge core_clk) disable iff (hold_rst)
        user_mode && !pass_end |=> $stable(cmp_ref_q))
        else $error("Compared reference changed inside a pass.");

    a_div_spacing: assert property (@(posedge core_clk) disable iff (hold_rst)
        tick && (div_n == 4'h1) |=> !tick ##1 tick)
        else $error("Divided check rate is wrong.");

endmodule : cmcrc_checker

// *** test/cmcrc_jtag_host.sv ***
`timescale 1ns/100ps

// ****************************************
// JTAG host stand-in for the reference scan chain
// ****************************************

module cmcrc_jtag_host
(
    input  wire logic core_clk,
    input  wire logic ref_tdo,
    output logic      load_reference_instr,
    output logic      ref_shift,
    output logic      ref_tdi
);

    // Lines start quiet; no instruction is active before the first scan.
    initial
    begin
        load_reference_instr = 1'b0;
        ref_shift            = 1'b0;
        ref_tdi              = 1'b0;
    end

    // Replaces the reference LSB first; the bits that fall out are the old value, so it is read out first.
    task automatic scan(input logic [31:0] new_val, output logic [31:0] old_val);
        @(negedge core_clk);
        load_reference_instr = 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            old_val[i] = ref_tdo;
            ref_tdi    = new_val[i];
            ref_shift  = 1'b1;
            @(negedge core_clk);
        end
        ref_shift            = 1'b0;
        load_reference_instr = 1'b0;
        // A released data line shows the inverse of its last bit, so stale data never looks valid.
        ref_tdi              = ~ref_tdi;
    endtask : scan

endmodule : cmcrc_jtag_host

// *** test/config_memory_crc_checker_tb.sv ***
`timescale 1ns/100ps

`include "cmcrc_map.svh"

module config_memory_crc_checker_tb;
    import cmcrc_pkg::*;

    logic                core_clk;
    logic                rst;
    logic                config_restart_n;
    logic                check_enable;
    logic [3:0]          div_exp;
    logic                cfg_valid;
    cmcrc_kind_t         cfg_kind;
    logic [31:0]         cfg_word;
    logic                load_reference_instr;
    logic                ref_shift;
    logic                ref_tdi;
    logic                ref_tdo;
    logic                config_done;
    logic                config_frame_error;
    logic                user_mode;
    logic [31:0]         crc_check_signature;
    logic                crc_error;
    logic [31:0]         cells [4];
    logic [31:0]         ref_val;
    logic [31:0]         old_val;
    int                  n_high;
    int                  n_errors;
    int                  cmp_count;

    // ****************************************
    // Design, host model and clock
    // ****************************************

    cmcrc_checker #(.CELL_WORDS(4)) i_cmcrc_checker
    (
        .core_clk(core_clk), .rst(rst), .config_restart_n(config_restart_n), .check_enable(check_enable),
        .div_exp(div_exp), .cfg_valid(cfg_valid), .cfg_kind(cfg_kind), .cfg_word(cfg_word),
        .load_reference_instr(load_reference_instr), .ref_shift(ref_shift), .ref_tdi(ref_tdi),
        .ref_tdo(ref_tdo), .config_done(config_done), .config_frame_error(config_frame_error),
        .user_mode(user_mode), .crc_check_signature(crc_check_signature), .crc_error(crc_error)
    );

    cmcrc_jtag_host i_cmcrc_jtag_host
    (
        .core_clk(core_clk), .ref_tdo(ref_tdo), .load_reference_instr(load_reference_instr),
        .ref_shift(ref_shift), .ref_tdi(ref_tdi)
    );

    // The clock runs at 100 MHz.
    always #5 core_clk = ~core_clk;

    // ****************************************
    // Helpers
    // ****************************************

    // Folds one word into a running CRC, MSB first, written apart from the design on purpose.
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--)
        begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ `CMCRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_word

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic send(input cmcrc_kind_t kind, input logic [31:0] word);
        @(negedge core_clk);
        cfg_valid = 1'b1;
        cfg_kind  = kind;
        cfg_word  = word;
    endtask : send

    // Two frames of two words, back to back, then the reference word; bad spoils both frame checks.
    task automatic load_image(input logic bad);
        for (int f = 0; f < 2; f++)
        begin
            send(CMCRC_KIND_DATA, cells[2*f]);
            send(CMCRC_KIND_DATA, cells[2*f+1]);
            send(CMCRC_KIND_FRAME, crc_word(crc_word(`CMCRC_CRC_INIT, cells[2*f]), cells[2*f+1]) ^ {31'd0, bad});
        end
        send(CMCRC_KIND_REF, ref_val);
        @(negedge core_clk);
        cfg_valid = 1'b0;
        cfg_word  = ~cfg_word;
    endtask : load_image

    // Waits under a bound for the fault output to reach a level, then compares it.
    task automatic wait_error(input logic exp);
        for (int k = 0; k < 200 && crc_error !== exp; k++)
        begin
            @(negedge core_clk);
        end
        chk("crc_error", {31'd0, exp}, {31'd0, crc_error});
    endtask : wait_error

    task automatic do_reset;
        rst = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("outputs in reset", 32'h0000_0000, {config_done, user_mode, crc_error, crc_check_signature[28:0]});
        rst = 1'b0;
    endtask : do_reset

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // Tests
    // ****************************************

    // A run takes under two hundred cycles; the watchdog allows about ten thousand.
    initial
    begin
        #100000;
        n_errors++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        report_and_stop();
    end

    initial
    begin
        core_clk = 1'b0; rst = 1'b1; config_restart_n = 1'b1; check_enable = 1'b1; div_exp = 4'h0;
        cfg_valid = 1'b0; cfg_kind = CMCRC_KIND_DATA; cfg_word = 32'h0000_0000;
        n_errors = 0; cmp_count = 0;
        cells = '{32'h1234_5678, 32'hDEAD_BEEF, 32'h0F0F_A5A5, 32'h8000_0001};
        ref_val = `CMCRC_CRC_INIT;
        foreach (cells[i]) ref_val = crc_word(ref_val, cells[i]);
        do_reset();
        load_image(1'b0);
        chk("config_frame_error", 32'h0, {31'd0, config_frame_error});
        chk("config_done/user_mode", 32'h3, {30'd0, config_done, user_mode});
        // Every pass after a clean load must leave the fault low, the first one included.
        n_high = 0;
        repeat (20)
        begin
            @(negedge core_clk);
            if (crc_error !== 1'b0)
                n_high++;
        end
        chk("crc_error highs on clean passes", 32'h0, n_high);
        chk("clean signature", 32'h0000_0000, crc_check_signature);
        wait_error(1'b0);
        div_exp = 4'h1;
        i_cmcrc_jtag_host.scan(ref_val ^ 32'h0000_0001, old_val);
        chk("reference read out", ref_val, old_val);
        chk("user_mode during scan", 32'h1, {31'd0, user_mode});
        // Passes that ended during the scan compared against half-shifted values; let two whole passes go by.
        repeat (20) @(negedge core_clk);
        wait_error(1'b1);
        chk("faulty signature", 32'h0000_0001, crc_check_signature);
        repeat (12) @(negedge core_clk);
        chk("fault held", 32'h1, {31'd0, crc_error});
        i_cmcrc_jtag_host.scan(ref_val, old_val);
        chk("injected value read out", ref_val ^ 32'h0000_0001, old_val);
        wait_error(1'b0);
        chk("restored signature", 32'h0000_0000, crc_check_signature);
        config_restart_n = 1'b0;
        @(negedge core_clk);
        chk("restart stops checking", 32'h0, {30'd0, user_mode, config_done});
        config_restart_n = 1'b1;
        div_exp = 4'h0;
        load_image(1'b1);
        chk("config_frame_error", 32'h1, {31'd0, config_frame_error});
        chk("load stops on mismatch", 32'h0, {30'd0, config_done, user_mode});
        check_enable = 1'b0;
        do_reset();
        load_image(1'b0);
        chk("checking disabled", 32'h2, {30'd0, config_done, user_mode});
        report_and_stop();
    end

endmodule : config_memory_crc_checker_tb
